// >>> shared/aps_pkg.sv
// Purpose: constants for the async/page pseudo-static memory controller
// Assumes: 10 MHz clk, 100 ns period
// Notes:   the controller drives the memory pins; the memory holds config_word
package aps_pkg;
    localparam int CLK_NS           = 100;
    localparam int INIT_US          = 150;
    localparam int SLEEP_US         = 10;
    localparam int INIT_CYC         = (INIT_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int SLEEP_CYC        = (SLEEP_US * 1000) / CLK_NS + 1;
    localparam int ACCESS_NS        = 70;
    localparam int ACCESS_CYC       = (ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
    localparam int SELLOW_NS        = 4000;
    localparam int SELLOW_CYC       = SELLOW_NS / CLK_NS;
    localparam logic [20:0] SW_ADDR = 21'h01ffff;
    localparam logic [20:0] CFG_RST = 21'h000070;
    localparam logic [20:0] CFG_RSVD = 21'h1fff08;
    // software register offsets
    localparam logic [3:0] R_CTRL   = 4'h0;
    localparam logic [3:0] R_ADDR   = 4'h1;
    localparam logic [3:0] R_WDATA  = 4'h2;
    localparam logic [3:0] R_RDATA  = 4'h3;
    localparam logic [3:0] R_STAT   = 4'h4;
    // commands written to R_CTRL bits 2..0
    localparam logic [2:0] C_READ   = 3'h1;
    localparam logic [2:0] C_WRITE  = 3'h2;
    localparam logic [2:0] C_CFGWR  = 3'h3;
    localparam logic [2:0] C_CFGRD  = 3'h4;
    localparam logic [2:0] C_PINCFG = 3'h5;
    localparam logic [2:0] C_SLEEP  = 3'h6;
    localparam logic [2:0] C_WAKE   = 3'h7;
    localparam int CTRL_BE_LSB      = 3;
endpackage

// >>> core/aps_timer.sv
// Purpose: down counter for pin timing
// Assumes: load wins over counting
// Notes:   done is high while the count is zero
`timescale 1ns/10ps
module aps_timer #(
    parameter int W = 12
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              done
);
    logic [W-1:0] cnt_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= '0;
        end else if (load) begin
            cnt_ff <= value;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - W'(1);
        end
    end

    assign done = (cnt_ff == '0);
endmodule

// >>> core/aps_ctrl.sv
// Purpose: host controller driving the pseudo-static memory pins
// Assumes: plain register port, read data one cycle after read strobe
// Notes:   one command at a time; busy reads back in the status register
`timescale 1ns/10ps
module aps_ctrl #(
    parameter int INIT_CYCLES = aps_pkg::INIT_CYC,
    parameter int TW          = 12
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic [20:0]      mem_addr,
    output logic [15:0]      mem_dq_out,
    output logic             mem_dq_oe,
    input  wire logic [15:0] mem_dq_in,
    output logic             mem_cs_n,
    output logic             mem_we_n,
    output logic             mem_oe_n,
    output logic             low_byte_select_n,
    output logic             high_byte_select_n,
    output logic             sleep_pin_n
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [6:0] {
        S_INIT  = 7'h01,
        S_IDLE  = 7'h02,
        S_SETUP = 7'h04,
        S_STROB = 7'h08,
        S_GAP   = 7'h10,
        S_SLEEP = 7'h20,
        S_ZZLD  = 7'h40
    } aps_state_t;

    aps_state_t  st_ff;
    logic [2:0]  cmd_ff;
    logic [1:0]  step_ff;
    logic        step_wr;
    logic [20:0] addr_ff;
    logic [15:0] wdata_ff;
    logic [15:0] rdata_ff;
    logic [1:0]  be_ff;
    logic        done_ff;
    logic        sleep_ff;
    logic        tload;
    logic [TW-1:0] tval;
    logic        tdone;
    logic        go;
    logic        init_ld_ff;

    aps_timer #(.W(TW)) u_tmr (
        .clk   (clk),
        .rst   (rst),
        .load  (tload),
        .value (tval),
        .done  (tdone)
    );

    // software sequence: read,read,write,write; config read makes step 3 a read
    function automatic logic is_write(input logic [2:0] c, input logic [1:0] s);
        case (c)
            aps_pkg::C_WRITE:  is_write = 1'b1;
            aps_pkg::C_PINCFG: is_write = 1'b1;
            aps_pkg::C_CFGWR:  is_write = s[1];
            aps_pkg::C_CFGRD:  is_write = (s == 2'd2);
            default:           is_write = 1'b0;
        endcase
    endfunction

    function automatic logic multi(input logic [2:0] c);
        multi = (c == aps_pkg::C_CFGWR) || (c == aps_pkg::C_CFGRD);
    endfunction

    assign step_wr = is_write(cmd_ff, step_ff);
    assign go      = reg_wr && (reg_addr == aps_pkg::R_CTRL)
                     && (st_ff == S_IDLE || st_ff == S_SLEEP);

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff   <= S_INIT;
            step_ff <= 2'd0;
            cmd_ff  <= 3'd0;
        end else begin
            case (st_ff)
                S_INIT: begin
                    if (tdone && !init_ld_ff) begin
                        st_ff <= S_IDLE;
                    end
                end
                S_IDLE: begin
                    if (go) begin
                        cmd_ff  <= reg_wdata[2:0];
                        step_ff <= 2'd0;
                        case (reg_wdata[2:0])
                            aps_pkg::C_READ, aps_pkg::C_WRITE, aps_pkg::C_CFGWR,
                            aps_pkg::C_CFGRD: st_ff <= S_SETUP;
                            aps_pkg::C_PINCFG, aps_pkg::C_SLEEP: st_ff <= S_ZZLD;
                            aps_pkg::C_WAKE: st_ff <= sleep_ff ? S_INIT : S_IDLE;
                            default: st_ff <= S_IDLE;
                        endcase
                    end
                end
                S_ZZLD: begin
                    if (tdone) begin
                        st_ff <= (cmd_ff == aps_pkg::C_SLEEP) ? S_SLEEP : S_SETUP;
                    end
                end
                S_SETUP: st_ff <= S_STROB;
                S_STROB: begin
                    if (tdone) begin
                        st_ff <= S_GAP;
                    end
                end
                S_GAP: begin
                    if (multi(cmd_ff) && step_ff != 2'd3) begin
                        step_ff <= step_ff + 2'd1;
                        st_ff   <= S_SETUP;
                    end else begin
                        st_ff <= S_IDLE;
                    end
                end
                S_SLEEP: begin
                    if (go && reg_wdata[2:0] == aps_pkg::C_WAKE) begin
                        st_ff <= S_INIT;
                    end
                end
                default: st_ff <= S_IDLE;
            endcase
        end
    end

    // first cycle after reset starts the power-up wait
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            init_ld_ff <= 1'b1;
        end else begin
            init_ld_ff <= 1'b0;
        end
    end

    // timer loads: power-up wait, sleep hold, pin-load hold, strobe width
    always_comb begin
        tload = 1'b0;
        tval  = '0;
        if (init_ld_ff) begin
            tload = 1'b1;
            tval  = TW'(INIT_CYCLES);
        end else if (st_ff == S_IDLE && go && reg_wdata[2:0] == aps_pkg::C_SLEEP) begin
            tload = 1'b1;
            tval  = TW'(aps_pkg::SLEEP_CYC);
        end else if (st_ff == S_IDLE && go && reg_wdata[2:0] == aps_pkg::C_PINCFG) begin
            tload = 1'b1;
            tval  = TW'(1);
        end else if ((st_ff == S_IDLE || st_ff == S_SLEEP) && go
                     && reg_wdata[2:0] == aps_pkg::C_WAKE && sleep_ff) begin
            tload = 1'b1;
            tval  = TW'(INIT_CYCLES);
        end else if (st_ff == S_SETUP) begin
            tload = 1'b1;
            tval  = TW'(aps_pkg::ACCESS_CYC);
        end
    end

    // sleep_ff marks the pin held low for a power-down, not a config load
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleep_ff <= 1'b0;
        end else if (st_ff == S_ZZLD && cmd_ff == aps_pkg::C_SLEEP && tdone) begin
            sleep_ff <= 1'b1;
        end else if (st_ff == S_INIT) begin
            sleep_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // operands
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_ff  <= '0;
            wdata_ff <= '0;
            be_ff    <= 2'b11;
        end else if (reg_wr && st_ff == S_IDLE) begin
            if (reg_addr == aps_pkg::R_ADDR) begin
                addr_ff <= reg_wdata[20:0];
            end
            if (reg_addr == aps_pkg::R_WDATA) begin
                wdata_ff <= reg_wdata[15:0];
            end
            if (reg_addr == aps_pkg::R_CTRL) begin
                be_ff <= reg_wdata[aps_pkg::CTRL_BE_LSB +: 2];
            end
        end
    end

    // capture read data on the last strobe cycle of a command's last step only (single read, or step 3 of a config read)
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= '0;
            done_ff  <= 1'b0;
        end else begin
            if (st_ff == S_STROB && tdone && !step_wr
                && (!multi(cmd_ff) || step_ff == 2'd3)) begin
                rdata_ff <= mem_dq_in;
            end
            if (go) begin
                done_ff <= 1'b0;
            end else if (st_ff == S_GAP && (!multi(cmd_ff) || step_ff == 2'd3)) begin
                done_ff <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // pins
    // ----------------------------------------
    logic        cfg_cmd;
    logic        pin_cfg;
    logic [20:0] nxt_addr;
    assign cfg_cmd = multi(cmd_ff);
    assign pin_cfg = (cmd_ff == aps_pkg::C_PINCFG);

    always_comb begin
        if (cfg_cmd) begin
            nxt_addr = aps_pkg::SW_ADDR;
        end else if (pin_cfg) begin
            nxt_addr = addr_ff & ~aps_pkg::CFG_RSVD;
        end else begin
            nxt_addr = addr_ff;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_cs_n           <= 1'b1;
            mem_we_n           <= 1'b1;
            mem_oe_n           <= 1'b1;
            low_byte_select_n  <= 1'b1;
            high_byte_select_n <= 1'b1;
            sleep_pin_n        <= 1'b1;
            mem_addr           <= '0;
            mem_dq_out         <= '0;
            mem_dq_oe          <= 1'b0;
        end else begin
            // pin stays low through a pin load or a power-down
            sleep_pin_n <= !(st_ff == S_ZZLD || st_ff == S_SLEEP
                             || (st_ff == S_SETUP && pin_cfg)
                             || (st_ff == S_STROB && pin_cfg));
            mem_addr    <= nxt_addr;
            if (st_ff == S_STROB && !tdone) begin
                mem_cs_n <= 1'b0;
                mem_we_n <= !step_wr;
                mem_oe_n <= step_wr;
                low_byte_select_n  <= cfg_cmd ? 1'b0 : !be_ff[0];
                high_byte_select_n <= cfg_cmd ? 1'b0 : !be_ff[1];
                mem_dq_oe  <= step_wr;
                // config write data: bits 15..0, reserved forced to zero
                mem_dq_out <= cfg_cmd ? (wdata_ff & ~aps_pkg::CFG_RSVD[15:0]) : wdata_ff;
            end else begin
                // all strobes rise together; data held one more cycle
                mem_cs_n <= 1'b1;
                mem_we_n <= 1'b1;
                mem_oe_n <= 1'b1;
                low_byte_select_n  <= 1'b1;
                high_byte_select_n <= 1'b1;
                mem_dq_oe <= (st_ff == S_STROB) && step_wr;
            end
        end
    end

    // ----------------------------------------
    // register read port
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                aps_pkg::R_CTRL:  reg_rdata <= {27'h0, be_ff, cmd_ff};
                aps_pkg::R_ADDR:  reg_rdata <= {11'h0, addr_ff};
                aps_pkg::R_WDATA: reg_rdata <= {16'h0, wdata_ff};
                aps_pkg::R_RDATA: reg_rdata <= {16'h0, rdata_ff};
                aps_pkg::R_STAT:  reg_rdata <= {28'h0, sleep_ff, done_ff,
                                                st_ff == S_INIT, st_ff != S_IDLE};
                default:          reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_init_cs_high: assert property (@(posedge clk) disable iff (rst)
        st_ff == S_INIT |=> mem_cs_n)
        else $error("chip select low during init");
    a_cs_low_bound: assert property (@(posedge clk) disable iff (rst)
        $fell(mem_cs_n) |-> ##[1:8] mem_cs_n)
        else $error("chip select low too long");
    a_we_oe_excl: assert property (@(posedge clk) disable iff (rst)
        !mem_we_n |-> mem_oe_n && mem_dq_oe)
        else $error("output enable with write");
    a_dq_hold_rise: assert property (@(posedge clk) disable iff (rst)
        $rose(mem_we_n) |-> mem_dq_oe && $stable(mem_dq_out))
        else $error("write data not held at strobe rise");
    a_sw_top_addr: assert property (@(posedge clk) disable iff (rst)
        (!mem_cs_n && cfg_cmd) |-> mem_addr == aps_pkg::SW_ADDR)
        else $error("software step off top address");
    a_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
        (!mem_we_n && !sleep_pin_n) |-> (mem_addr & aps_pkg::CFG_RSVD) == 21'h0)
        else $error("reserved config bit set");
    a_read_oe: assert property (@(posedge clk) disable iff (rst)
        (!mem_oe_n) |-> !mem_cs_n && mem_we_n && !mem_dq_oe)
        else $error("bad read strobes");
    a_sleep_wait: assert property (@(posedge clk) disable iff (rst)
        $rose(sleep_ff) |-> $past(st_ff) == S_ZZLD
                            && $past(sleep_pin_n, aps_pkg::SLEEP_CYC - 1) == 1'b0)
        else $error("sleep flagged without hold");
    c_read: cover property (@(posedge clk) disable iff (rst) $fell(mem_oe_n));
    c_write: cover property (@(posedge clk) disable iff (rst) $fell(mem_we_n));
    c_cfg_sw: cover property (@(posedge clk) disable iff (rst)
        cfg_cmd && st_ff == S_GAP && step_ff == 2'd3);
    c_sleep: cover property (@(posedge clk) disable iff (rst) $rose(sleep_ff));
endmodule

// >>> dv/aps_mem_model.sv
// Purpose: behavioural pseudo-static memory facing the controller
// Assumes: no clock; reacts to pin levels and edges only
// Notes:   lost or undriven data reads back as a changing pattern
`timescale 1ns/10ps
module aps_mem_model #(
    parameter int INIT_NS = 150000
) (
    input  wire logic [20:0] mem_addr,
    input  wire logic [15:0] mem_dq_out,
    input  wire logic        mem_dq_oe,
    output logic      [15:0] mem_dq_in,
    input  wire logic        mem_cs_n,
    input  wire logic        mem_we_n,
    input  wire logic        mem_oe_n,
    input  wire logic        low_byte_select_n,
    input  wire logic        high_byte_select_n,
    input  wire logic        sleep_pin_n
);
    // ----------------------------------------
    // array, config word and access tracking
    // ----------------------------------------
    logic [15:0] mem [logic [20:0]];
    logic [20:0] cfg = aps_pkg::CFG_RST;
    logic [20:0] wadr, radr;
    logic [15:0] wdat, rdat;
    logic [15:0] last = 16'h0000;
    logic [5:0]  hist = 6'h00;
    logic [1:0]  ln, lnw;
    logic        ready = 1'b0, asleep = 1'b0, armed = 1'b0;
    logic        swld = 1'b0, wact = 1'b0, ract = 1'b0;
    time         t_fall = 0, zz_due = 0;
    function automatic logic [15:0] fetch(input logic [20:0] a);
        return mem.exists(a) ? mem[a] : (16'hc3a5 ^ a[15:0]);
    endfunction
    initial #(INIT_NS) ready = 1'b1;
    // every fall schedules its own 10 us check, so a second fall is never missed
    always @(negedge sleep_pin_n) begin
        armed = 1'b1;
        t_fall = $time;
        zz_due <= #(10000) $time;
    end
    always @(zz_due) begin
        if (!sleep_pin_n && zz_due == t_fall && !(cfg[4] && swld)) begin
            asleep = 1'b1;
            if (!cfg[4] || cfg[2:0] == 3'h4) mem.delete();
        end
    end
    always @(posedge sleep_pin_n) begin
        armed = 1'b0;
        if (asleep && !cfg[4]) begin
            asleep = 1'b0;
            ready = 1'b0;
            #(INIT_NS) ready = 1'b1;
        end else asleep = 1'b0;
    end
    always @(mem_cs_n or mem_we_n or mem_oe_n or low_byte_select_n or high_byte_select_n
             or mem_addr or mem_dq_out or ready or asleep) begin
        ln = ~{high_byte_select_n, low_byte_select_n};
        if (!ready || asleep) begin
            wact = 1'b0;
            ract = 1'b0;
        end else if (!mem_cs_n && !mem_we_n && (ln != 2'b00 || armed)) begin
            wact = 1'b1;
            wadr = mem_addr;
            wdat = mem_dq_out;
            lnw = ln;
        end else if (wact) begin
            wact = 1'b0;
            if (armed && !sleep_pin_n) begin
                cfg = wadr;
                armed = 1'b0;
            end else if (wadr == aps_pkg::SW_ADDR && hist == 6'h16) begin
                cfg[15:0] = wdat;
                swld = 1'b1;
            end else if (!(wadr == aps_pkg::SW_ADDR && hist[3:0] == 4'h5)) begin
                rdat = fetch(wadr);
                if (lnw[0]) rdat[7:0] = wdat[7:0];
                if (lnw[1]) rdat[15:8] = wdat[15:8];
                mem[wadr] = rdat;
            end
            hist = {hist[3:0], (wadr == aps_pkg::SW_ADDR) ? 2'h2 : 2'h0};
        end else if (!mem_cs_n && mem_we_n && !mem_oe_n && ln != 2'b00) begin
            ract = 1'b1;
            radr = mem_addr;  // untimed: page and random reads alike
            rdat = (radr == aps_pkg::SW_ADDR && hist == 6'h16) ? cfg[15:0] : fetch(radr);
            rdat[7:0] = ln[0] ? rdat[7:0] : ~last[7:0];
            rdat[15:8] = ln[1] ? rdat[15:8] : ~last[15:8];
            mem_dq_in = rdat;
            last = rdat;
        end else if (ract) begin
            ract = 1'b0;
            hist = {hist[3:0], (radr == aps_pkg::SW_ADDR) ? 2'h1 : 2'h0};
        end
        if (!ract) mem_dq_in = ~last;
    end
endmodule

// >>> dv/tb_async_page_psram_interface.sv
// Purpose: self-checking bench for the memory controller
// Assumes: register port with read data one cycle after the strobe
// Notes:   init wait shortened to 20 cycles
`timescale 1ns/10ps
module tb_async_page_psram_interface;
    // ----------------------------------------
    // signals, instances, bus tasks
    // ----------------------------------------
    logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
    logic [20:0] mem_addr;
    logic [15:0] mem_dq_out, mem_dq_in;
    logic        mem_dq_oe, mem_cs_n, mem_we_n, mem_oe_n, sleep_pin_n;
    logic        low_byte_select_n, high_byte_select_n;
    int          err_count = 0, checked = 0, n;
    aps_ctrl #(.INIT_CYCLES(20)) i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mem_addr(mem_addr), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe),
        .mem_dq_in(mem_dq_in), .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n),
        .low_byte_select_n(low_byte_select_n), .high_byte_select_n(high_byte_select_n),
        .sleep_pin_n(sleep_pin_n));
    aps_mem_model #(.INIT_NS(2000)) i_mem (.mem_addr(mem_addr), .mem_dq_out(mem_dq_out),
        .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in), .mem_cs_n(mem_cs_n),
        .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .low_byte_select_n(low_byte_select_n),
        .high_byte_select_n(high_byte_select_n), .sleep_pin_n(sleep_pin_n));
    initial forever #50 clk = ~clk;
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic poll();
        n = 0;
        do begin
            rd(aps_pkg::R_STAT, v);
            n++;
        end while (v[0] !== 1'b0 && n < 400);
        if (v[0] !== 1'b0) chk("busy_clear", 32'h0, {31'h0, v[0]});
    endtask
    task automatic op(input logic [2:0] c, input logic [1:0] be, input logic [20:0] a,
                      input logic [15:0] d);
        wr(aps_pkg::R_ADDR, {11'h000, a});
        wr(aps_pkg::R_WDATA, {16'h0000, d});
        wr(aps_pkg::R_CTRL, {27'h0, be, c});
        poll();
    endtask
    task automatic rdchk(input string what, input logic [20:0] a, input logic [1:0] be,
                         input logic [15:0] exp, input logic [15:0] mask);
        op(aps_pkg::C_READ, be, a, 16'h0000);
        rd(aps_pkg::R_RDATA, v);
        chk(what, {16'h0, exp & mask}, v & {16'h0, mask});
    endtask
    task automatic cfgchk(input logic [15:0] exp);
        op(aps_pkg::C_CFGRD, 2'b11, 21'h0, 16'h0000);
        rd(aps_pkg::R_RDATA, v);
        chk("config_word", {16'h0, exp}, v & 32'hffff);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_init();
        rd(aps_pkg::R_STAT, v);
        chk("init_flag", 32'h1, {31'h0, v[1]});
        repeat (12) begin
            @(posedge clk);
            #1 chk("cs_in_init", 32'h1, {31'h0, mem_cs_n});
        end
        poll();
        chk("init_done", 32'h0, {31'h0, v[1]});
    endtask
    task automatic t_rw();
        op(aps_pkg::C_WRITE, 2'b11, 21'h000123, 16'h1234);
        chk("done_flag", 32'h1, {31'h0, v[2]});
        op(aps_pkg::C_WRITE, 2'b11, 21'h000124, 16'hbeef);
        rdchk("word", 21'h000123, 2'b11, 16'h1234, 16'hffff);
        rdchk("word_next", 21'h000124, 2'b11, 16'hbeef, 16'hffff);
    endtask
    task automatic t_lanes();
        op(aps_pkg::C_WRITE, 2'b01, 21'h000123, 16'habcd);
        rdchk("low_lane_wr", 21'h000123, 2'b11, 16'h12cd, 16'hffff);
        op(aps_pkg::C_WRITE, 2'b10, 21'h000123, 16'h5566);
        rdchk("high_lane_wr", 21'h000123, 2'b11, 16'h55cd, 16'hffff);
        op(aps_pkg::C_WRITE, 2'b00, 21'h000123, 16'h0000);
        rdchk("no_lane_wr", 21'h000123, 2'b11, 16'h55cd, 16'hffff);
        rdchk("low_lane_rd", 21'h000123, 2'b01, 16'h55cd, 16'h00ff);
        rdchk("high_lane_rd", 21'h000123, 2'b10, 16'h55cd, 16'hff00);
    endtask
    task automatic t_cfg();
        op(aps_pkg::C_WRITE, 2'b11, aps_pkg::SW_ADDR, 16'h5a5a);
        cfgchk(16'h0070);
        op(aps_pkg::C_CFGWR, 2'b11, 21'h0, 16'h0031);
        cfgchk(16'h0031);
        rdchk("top_word", aps_pkg::SW_ADDR, 2'b11, 16'h5a5a, 16'hffff);
    endtask
    task automatic t_pin();
        op(aps_pkg::C_PINCFG, 2'b11, 21'h1fff6c, 16'h0000);
        chk("pin_idle", 32'h1, {31'h0, sleep_pin_n});
        cfgchk(16'h0064);
    endtask
    task automatic t_sleep();
        wr(aps_pkg::R_CTRL, {27'h0, 2'b11, aps_pkg::C_SLEEP});
        n = 0;
        repeat (300) begin
            @(posedge clk);
            #1 if (sleep_pin_n === 1'b0) n++;
        end
        chk("pin_low_span", 32'h1, {31'h0, n >= aps_pkg::SLEEP_CYC});
        rd(aps_pkg::R_STAT, v);
        chk("sleep_flag", 32'h1, {31'h0, v[3]});
        wr(aps_pkg::R_CTRL, {27'h0, 2'b11, aps_pkg::C_WAKE});
        rd(aps_pkg::R_STAT, v);
        chk("wake_busy", 32'h1, {31'h0, v[0]});
        poll();
        chk("pin_woken", 32'h1, {31'h0, sleep_pin_n});
        wr(aps_pkg::R_ADDR, {11'h000, 21'h000200});
        wr(aps_pkg::R_WDATA, 32'h1111);
        wr(aps_pkg::R_CTRL, {27'h0, 2'b11, aps_pkg::C_WRITE});
        wr(aps_pkg::R_WDATA, 32'h2222);
        poll();
        rd(aps_pkg::R_WDATA, v);
        chk("wdata_kept", 32'h1111, v);
        rdchk("busy_refused", 21'h000200, 2'b11, 16'h1111, 16'hffff);
        rd(4'hf, v);
        chk("unmapped", 32'h0, v);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_init();
        t_rw();
        t_lanes();
        t_cfg();
        t_pin();
        t_sleep();
        end_of_test();
    end
    initial begin
        #(4ms);
        err_count++;
        end_of_test();
    end
endmodule
